/* acs_pkg.sv */
/*
 * constants, layouts and helpers for the conversion sequencer of a
 * 10-bit successive-approximation converter.
 * assumes the system clock is the high-frequency clock fc, so every
 * conversion time below counts clk cycles directly.
 */
// Summary of operation
// - mode 01: start bit begins one conversion
// - finish: store result, set flag, interrupt together
// - start bit clears itself once conversion begins
// - mode 11: start bit begins repeating conversions
// - repeat mode relaunches after each completion
// - writing mode 00 halts conversion at once
// - aborted conversion leaves result registers unchanged
// - reading result high clears end-of-conversion flag
// - new start clears flag, old result kept
// - time codes select 39 to 1248 fc
// - of the two result reads, only the high one clears the flag
// - busy flag high from start to finish
// - control one written 00: starts ignored four cycles
package acs_pkg;
    // byte addresses of the word registers
    localparam logic [7:0] ADR_CTL1 = 8'h00;
    localparam logic [7:0] ADR_CTL2 = 8'h04;
    localparam logic [7:0] ADR_RES_LO = 8'h08;
    localparam logic [7:0] ADR_RES_HI = 8'h0C;
    localparam logic [7:0] ADR_IRQ_ST = 8'h10;
    localparam logic [7:0] ADR_IRQ_MSK = 8'h14;
    // operating modes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SW = 2'h1;
    localparam logic [1:0] MODE_REP = 2'h3;
    // reset values
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [5:0] CTL2_RST = 6'h00;
    // result_low field positions
    localparam int LO_EOC_BIT = 5;
    localparam int LO_BUSY_BIT = 4;
    // start blackout after control one is cleared, in cycles
    localparam logic [2:0] BLK_CYC = 3'h4;
    // conversion times in fc periods
    localparam int CT_A_FC = 39;
    localparam int CT_C_FC = 78;
    localparam int CT_D_FC = 156;
    localparam int CT_E_FC = 312;
    localparam int CT_F_FC = 624;
    localparam int CT_G_FC = 1248;
    // first control register layout
    typedef struct packed {
        logic start;
        logic [1:0] mode;
        logic ain_en;
        logic [3:0] chan;
    } acs_ctl1_t;
    // second control register layout
    typedef struct packed {
        logic ref_on;
        logic fix_one;
        logic [2:0] ctime;
        logic fix_zero;
    } acs_ctl2_t;
    // code to load for a conversion time: cycles minus one
    function automatic logic [10:0] acs_conv_load(input logic [2:0] code);
        int n;
        n = CT_G_FC; // reserved codes fall back to the longest time
        case (code)
            3'h0: n = CT_A_FC;
            3'h2: n = CT_C_FC;
            3'h3: n = CT_D_FC;
            3'h4: n = CT_E_FC;
            3'h5: n = CT_F_FC;
            3'h6: n = CT_G_FC;
            default: n = CT_G_FC;
        endcase
        return 11'(n - 1);
    endfunction
endpackage

/* acs_sequencer.sv */
/*
 * conversion sequencer: avalon-mm register slave, start and repeat
 * control, conversion timer, result registers and interrupt.
 * assumes the analog path presents a settled 10-bit code on
 * adc_sample by the last cycle of each conversion time.
 */
`timescale 1ns/1ps
module acs_sequencer
    import acs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analog path
    input wire logic [9:0] adc_sample,
    output logic [3:0] channel_select,
    output logic analog_input_enable,
    output logic ref_current_on,
    output logic conv_busy,
    // interrupt
    output logic conv_done_irq
);
    typedef enum logic {ACS_IDLE, ACS_CONV} acs_state_t;

    acs_state_t state_q; // conversion state
    acs_ctl1_t ctl1_q; // first control register
    acs_ctl2_t ctl2_q; // second control register
    logic [7:0] res_hi_q; // upper eight result bits
    logic [1:0] res_lo_q; // lower two result bits
    logic eoc_q; // end_of_conv_flag
    logic irq_st_q; // sticky completion status
    logic irq_msk_q; // completion mask
    logic [10:0] cnt_q; // remaining conversion cycles
    logic [2:0] blk_q; // start blackout count
    logic ack_q; // one wait state marker
    logic [31:0] rdata_q; // read data register

    logic req; // any bus request
    logic acc; // request completes this edge
    logic wr_en; // write takes effect
    logic rd_en; // read takes effect
    logic ctl1_we; // write to first control register
    logic abort; // disable write halts conversion
    logic busy; // conversion running
    logic done; // conversion ends this edge
    logic launch; // start accepted this edge
    logic hi_rd; // read of result_high

    // bus handshake: every access gets exactly one wait state
    assign req = avs_read | avs_write;
    assign acc = req & ack_q;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_en = avs_write & ack_q & avs_byteenable[0];
    assign rd_en = avs_read & ack_q;
    assign ctl1_we = wr_en & (avs_address == ADR_CTL1);
    assign hi_rd = rd_en & (avs_address == ADR_RES_HI);

    // halt as soon as software writes the disable mode
    assign abort = ctl1_we & (avs_writedata[6:5] == MODE_OFF);

    assign busy = (state_q == ACS_CONV);
    assign done = busy & (cnt_q == 11'h000) & ~abort;

    // a pending start is taken only in an active mode, outside blackout
    assign launch = ctl1_q.start & ~busy & (blk_q == 3'h0)
        & ((ctl1_q.mode == MODE_SW) | (ctl1_q.mode == MODE_REP));

    // ack marker toggles so each access sees one waiting cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // first control register with self-clearing start bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl1_q <= acs_ctl1_t'(CTL1_RST);
        end else if (ctl1_we) begin
            ctl1_q <= acs_ctl1_t'(avs_writedata[7:0]);
        end else if (ctl1_q.start) begin
            // start stands one cycle: taken by launch or dropped, so a start
            // in a dead mode or inside the blackout is ignored, not deferred
            ctl1_q.start <= 1'b0;
        end
    end

    // second control register; bits 7:6 are not stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl2_q <= acs_ctl2_t'(CTL2_RST);
        end else if (wr_en & (avs_address == ADR_CTL2)) begin
            ctl2_q <= acs_ctl2_t'(avs_writedata[5:0]);
        end
    end

    // blackout after control one is written with all zeros
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blk_q <= 3'h0;
        end else if (ctl1_we & (avs_writedata[7:0] == 8'h00)) begin
            blk_q <= BLK_CYC;
        end else if (blk_q != 3'h0) begin
            blk_q <= blk_q - 3'h1;
        end
    end

    // conversion state and timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ACS_IDLE;
            cnt_q <= 11'h000;
        end else begin
            case (state_q)
                ACS_IDLE: begin
                    if (launch) begin
                        state_q <= ACS_CONV;
                        cnt_q <= acs_conv_load(ctl2_q.ctime);
                    end
                end
                ACS_CONV: begin
                    if (abort) begin
                        state_q <= ACS_IDLE;
                    end else if (cnt_q != 11'h000) begin
                        cnt_q <= cnt_q - 11'h001;
                    end else if (ctl1_q.mode == MODE_REP) begin
                        // back to back: no start write needed
                        cnt_q <= acs_conv_load(ctl2_q.ctime);
                    end else begin
                        state_q <= ACS_IDLE;
                    end
                end
                default: begin
                    state_q <= ACS_IDLE;
                end
            endcase
        end
    end

    // result registers only move on a completed conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_hi_q <= 8'h00;
            res_lo_q <= 2'h0;
        end else if (done) begin
            res_hi_q <= adc_sample[9:2];
            res_lo_q <= adc_sample[1:0];
        end
    end

    // end-of-conversion flag: completion wins over a clearing read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eoc_q <= 1'b0;
        end else if (done) begin
            eoc_q <= 1'b1;
        end else if (hi_rd | launch) begin
            // low-half read leaves it alone so both halves match
            eoc_q <= 1'b0;
        end
    end

    // interrupt status, write one to clear, set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_st_q <= 1'b0;
        end else if (done) begin
            irq_st_q <= 1'b1;
        end else if (wr_en & (avs_address == ADR_IRQ_ST) & avs_writedata[0]) begin
            irq_st_q <= 1'b0;
        end
    end

    // interrupt mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_msk_q <= 1'b0;
        end else if (wr_en & (avs_address == ADR_IRQ_MSK)) begin
            irq_msk_q <= avs_writedata[0];
        end
    end

    // read data captured in the waiting cycle; unmapped reads give zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read & ~ack_q) begin
            case (avs_address)
                ADR_CTL1: rdata_q <= {24'h00_0000, ctl1_q};
                ADR_CTL2: rdata_q <= {26'h000_0000, ctl2_q};
                ADR_RES_LO: rdata_q <= {24'h00_0000, res_lo_q, eoc_q, busy, 4'h0};
                ADR_RES_HI: rdata_q <= {24'h00_0000, res_hi_q};
                ADR_IRQ_ST: rdata_q <= {31'h0000_0000, irq_st_q};
                ADR_IRQ_MSK: rdata_q <= {31'h0000_0000, irq_msk_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // outputs
    assign avs_readdata = rdata_q;
    assign channel_select = ctl1_q.chan;
    assign analog_input_enable = ctl1_q.ain_en;
    assign ref_current_on = ctl2_q.ref_on;
    assign conv_busy = busy;
    assign conv_done_irq = irq_st_q & irq_msk_q;

    // accepted single start runs the conversion
    property p_sw_start;
        @(posedge clk) disable iff (!rst_n)
        (launch & ~ctl1_we) |=> busy;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("start not taken");

    // start bit never lingers after a conversion begins
    property p_start_clr;
        @(posedge clk) disable iff (!rst_n)
        (ctl1_q.start & busy & ~ctl1_we) |=> ~ctl1_q.start;
    endproperty
    a_start_clr: assert property (p_start_clr) else $error("start bit stuck");

    // completion stores the code and raises the flags together
    property p_done;
        @(posedge clk) disable iff (!rst_n)
        done |=> (eoc_q & irq_st_q & (res_hi_q == $past(adc_sample[9:2]))
            & (res_lo_q == $past(adc_sample[1:0])));
    endproperty
    a_done: assert property (p_done) else $error("completion not stored");

    // repeat mode keeps converting
    property p_repeat;
        @(posedge clk) disable iff (!rst_n)
        (done & (ctl1_q.mode == MODE_REP) & ~ctl1_we) |=> busy & (cnt_q != 11'h000);
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat stalled");

    // disable stops at once and keeps the old result
    property p_abort;
        @(posedge clk) disable iff (!rst_n)
        abort |=> ~busy & $stable(res_hi_q) & $stable(res_lo_q);
    endproperty
    a_abort: assert property (p_abort) else $error("abort failed");

    // high read clears the flag, low read does not
    property p_hi_read;
        @(posedge clk) disable iff (!rst_n)
        (hi_rd & ~done) |=> ~eoc_q;
    endproperty
    a_hi_read: assert property (p_hi_read) else $error("flag not cleared");

    property p_lo_read;
        @(posedge clk) disable iff (!rst_n)
        (rd_en & (avs_address == ADR_RES_LO) & eoc_q & ~launch) |=> eoc_q;
    endproperty
    a_lo_read: assert property (p_lo_read) else $error("low read cleared flag");

    // restart clears flag and keeps the previous result
    property p_restart;
        @(posedge clk) disable iff (!rst_n)
        launch |=> ~eoc_q & $stable(res_hi_q);
    endproperty
    a_restart: assert property (p_restart) else $error("restart mishandled");

    // shortest code takes exactly thirty-nine cycles
    property p_time;
        @(posedge clk) disable iff (!rst_n)
        ($rose(busy) & (ctl2_q.ctime == 3'h0) & ~abort) |-> ##38 (done | ~busy);
    endproperty
    a_time: assert property (p_time) else $error("conversion time wrong");

    // single conversion drops busy after finishing
    property p_busy;
        @(posedge clk) disable iff (!rst_n)
        (done & (ctl1_q.mode != MODE_REP)) |=> ~busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not cleared");

    // no conversion starts in the blackout
    property p_blackout;
        @(posedge clk) disable iff (!rst_n)
        (ctl1_we & (avs_writedata[7:0] == 8'h00)) |=> ~busy [*4];
    endproperty
    a_blackout: assert property (p_blackout) else $error("start in blackout");

    // a start landing inside the blackout is thrown away, not held over
    property p_blk_drop;
        @(posedge clk) disable iff (!rst_n)
        (ctl1_q.start & (blk_q != 3'h0) & ~ctl1_we) |=> ~ctl1_q.start & ~busy;
    endproperty
    a_blk_drop: assert property (p_blk_drop) else $error("blackout start kept");

    // an aborted conversion raises neither flag
    property p_abort_flags;
        @(posedge clk) disable iff (!rst_n)
        abort |=> $stable(eoc_q) & $stable(irq_st_q);
    endproperty
    a_abort_flags: assert property (p_abort_flags) else $error("abort raised a flag");

endmodule // acs_sequencer

/* acs_analog_model.sv */
/*
 * analog path model: the input mux and converter core as a code source.
 * assumes the sequencer drives the mux controls from its registers.
 */
`timescale 1ns/1ps
module acs_analog_model
    import acs_pkg::*;
(
    // mux control from the sequencer
    input wire logic [3:0] channel_select,
    input wire logic analog_input_enable,
    input wire logic ref_current_on,
    // settled code
    output logic [9:0] adc_sample
);
    // code names its channel; a disabled path gives an odd pattern, not zero
    assign adc_sample = (analog_input_enable && ref_current_on) ?
        {channel_select, 6'h2A} : 10'h3D5;
endmodule // acs_analog_model

/* acs_sequencer_tb.sv */
/*
 * bench for acs_sequencer: avalon tasks, timed conversion runs.
 * assumes a 10 MHz clock and acs_analog_model as the analog path.
 */
`timescale 1ns/1ps
module acs_sequencer_tb
    import acs_pkg::*;
;
    logic clk, rst_n, rd, wr;
    logic [7:0] adr;
    logic [31:0] wdata, rdata;
    logic [3:0] ben, chan;
    logic wait_req, busy, irq, ain, ref_on;
    logic [9:0] smp;
    int mismatches, comparisons, n;
    // expected busy length per time code; reserved codes run longest
    int ct[8] = '{CT_A_FC, CT_G_FC, CT_C_FC, CT_D_FC, CT_E_FC, CT_F_FC, CT_G_FC, CT_G_FC};
    acs_sequencer i_dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(ben), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .adc_sample(smp), .channel_select(chan),
        .analog_input_enable(ain), .ref_current_on(ref_on), .conv_busy(busy),
        .conv_done_irq(irq));
    acs_analog_model i_ana (.channel_select(chan), .analog_input_enable(ain),
        .ref_current_on(ref_on), .adc_sample(smp));
    // free-running 100 ns clock
    always #50 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one transfer, launched after an edge, held until waitrequest is low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        // hold everything until a rising edge samples waitrequest low
        do begin
            @(posedge clk);
            k++;
        end while (wait_req !== 1'b0 && k < 20);
        if (wait_req !== 1'b0) begin
            mismatches++;
            $display("mismatch waitrequest expected 0 seen %b", wait_req);
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 8'h00, q);
        chk(nm, {24'h0, e}, q);
    endtask
    // length of the next busy pulse in clocks; sampled mid-cycle to avoid races
    task automatic meas(output int c);
        int k;
        c = 0;
        k = 0;
        while (busy !== 1'b1 && k < 8) begin
            @(negedge clk);
            k++;
        end
        while (busy === 1'b1 && c < 2000) begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog at 40000 clocks; the whole run needs well under that
    initial begin
        #(100 * 40000);
        mismatches++;
        results();
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {rd, wr, adr, wdata} = '0;
        ben = 4'h1;
        mismatches = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and an unmapped hole
        rdc("ctl1", ADR_CTL1, CTL1_RST);
        rdc("res_lo", ADR_RES_LO, 8'h00);
        rdc("unmapped", 8'h18, 8'h00);
        wrt(ADR_IRQ_MSK, 8'h01);
        // every time code once, single start, channel follows the code
        for (int i = 0; i < 8; i++) begin
            wrt(ADR_CTL2, {2'b00, 1'b1, 1'b1, 3'(i), 1'b0});
            wrt(ADR_CTL1, {1'b1, MODE_SW, 1'b1, 4'(i)});
            meas(n);
            chk("ctime", ct[i], n);
            chk("irq", 1'b1, irq);
            rdc("ctl1", ADR_CTL1, {1'b0, MODE_SW, 1'b1, 4'(i)});
            rdc("res_lo", ADR_RES_LO, 8'hA0);
            rdc("res_lo", ADR_RES_LO, 8'hA0);
            rdc("res_hi", ADR_RES_HI, {4'(i), 4'hA});
            rdc("res_lo", ADR_RES_LO, 8'h80);
            rdc("irq_st", ADR_IRQ_ST, 8'h01);
            wrt(ADR_IRQ_ST, 8'h01);
            rdc("irq_st", ADR_IRQ_ST, 8'h00);
            chk("irq", 1'b0, irq);
        end
        // restart before the high read: flag drops, old result stays
        wrt(ADR_CTL2, 8'h30);
        wrt(ADR_CTL1, 8'hB5);
        meas(n);
        wrt(ADR_IRQ_ST, 8'h01);
        wrt(ADR_CTL2, 8'h3C);
        wrt(ADR_CTL1, 8'hB9);
        rdc("res_lo", ADR_RES_LO, 8'h90);
        rdc("res_hi", ADR_RES_HI, 8'h5A);
        // abort, then a start inside the blackout is dropped
        wrt(ADR_CTL1, 8'h00);
        wrt(ADR_CTL1, 8'hB9);
        rdc("res_lo", ADR_RES_LO, 8'h80);
        rdc("res_hi", ADR_RES_HI, 8'h5A);
        rdc("irq_st", ADR_IRQ_ST, 8'h00);
        rdc("ctl1", ADR_CTL1, 8'h39);
        // mode 10 is not a start mode
        wrt(ADR_CTL1, 8'hD9);
        rdc("res_lo", ADR_RES_LO, 8'h80);
        // repeat mode, interrupt masked at first
        wrt(ADR_CTL2, 8'h30);
        wrt(ADR_IRQ_MSK, 8'h00);
        wrt(ADR_CTL1, 8'hF3);
        repeat (100) @(posedge clk);
        chk("busy", 1'b1, busy);
        rdc("res_hi", ADR_RES_HI, 8'h3A);
        rdc("irq_st", ADR_IRQ_ST, 8'h01);
        chk("irq", 1'b0, irq);
        wrt(ADR_IRQ_MSK, 8'h01);
        repeat (50) @(posedge clk);
        rdc("res_lo", ADR_RES_LO, 8'hB0);
        chk("irq", 1'b1, irq);
        wrt(ADR_CTL1, 8'h13);
        rdc("ctl1", ADR_CTL1, 8'h13);
        chk("busy", 1'b0, busy);
        results();
    end
endmodule // acs_sequencer_tb
